// File: hdl/rpu_receive_pdo.sv
// Receive process-data unit: matches frames to receive channels and
// writes the mapped objects. Configuration via dictionary access port.
// Assumes the CAN controller and the NMT logic run on this clock and
// present each received frame as a one-cycle strobe.
`timescale 1ns/1ps
`include "rpu_defines.svh"
module rpu_receive_pdo
    import rpu_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Node address strap and network state
    input wire logic [6:0] node_id,
    input wire logic nmt_operational,
    input wire logic [10:0] sync_id,
    // Received frame from the CAN controller
    input wire logic frame_valid,
    input wire logic [10:0] frame_id,
    input wire logic frame_rtr,
    input wire logic [3:0] frame_len,
    input wire logic [63:0] frame_data,
    // Dictionary access from the service-data server
    input wire logic od_req,
    input wire logic od_write,
    input wire logic [15:0] od_index,
    input wire logic [7:0] od_sub,
    input wire logic [31:0] od_wdata,
    output logic od_ack,
    output logic od_abort,
    output logic [31:0] od_rdata,
    // Mapped object writes
    output logic obj_valid,
    output logic [((NUM_CH > 1) ? $clog2(NUM_CH) : 1)-1:0] obj_chan,
    output logic [15:0] obj_index,
    output logic [7:0] obj_sub,
    output logic [63:0] obj_value
);
    localparam int CW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

    // Total mapped bits of the first n entries
    function automatic logic [9:0] map_bits(input rpu_map_type m, input logic [2:0] n);
        logic [9:0] s;
        s = 10'h000;
        for (int e = 0; e < 4; e++) begin
            if (3'(e) < n) begin
                s = s + {2'b00, m[e*32 +: 8]};
            end
        end
        map_bits = s;
    endfunction : map_bits

    // Receive mapping only admits writable operation objects, so
    // configuration data stays reachable by dictionary access alone
    function automatic logic map_allowed(input logic [15:0] idx);
        map_allowed = (idx == `RPU_WR_CTRL) || (idx == `RPU_WR_SPEED) ||
            (idx == `RPU_WR_ACCEL) || (idx == `RPU_WR_DECEL);
    endfunction : map_allowed

    // ----------------------------------------
    // Node address capture
    // ----------------------------------------
    logic [6:0] node_m_r; // First synchroniser stage
    logic [6:0] node_s_r; // Second stage
    logic [1:0] boot_r; // Lets the strap settle after release
    logic loaded_r; // Default identifiers are in place

    // ----------------------------------------
    // Channel state
    // ----------------------------------------
    logic [31:0] id_r [NUM_CH];
    logic [7:0] tt_r [NUM_CH];
    logic [2:0] cnt_r [NUM_CH];
    rpu_map_type map_r [NUM_CH];
    logic [63:0] rxbuf_r [NUM_CH]; // Data held for the next SYNC, eight bytes per channel
    logic [63:0] updbuf_r [NUM_CH]; // Data waiting for the unpacker
    logic [NUM_CH-1:0] held_r; // rxbuf_r is waiting for SYNC
    logic [NUM_CH-1:0] upd_r; // updbuf_r is waiting to unpack
    logic od_ack_r;
    logic od_abort_r;
    logic [31:0] od_rdata_r;

    // ----------------------------------------
    // Frame matching
    // ----------------------------------------
    logic [NUM_CH-1:0] match;
    logic [NUM_CH-1:0] sync_type;
    logic [NUM_CH-1:0] take;
    logic [9:0] need_bits [NUM_CH];
    // Longer length codes still carry eight bytes
    wire [3:0] len_c = (frame_len > 4'h8) ? 4'h8 : frame_len;
    wire [9:0] have_bits = {3'b000, len_c, 3'b000};
    wire rx_ok = nmt_operational & loaded_r & frame_valid & ~frame_rtr;
    wire is_sync = rx_ok & (frame_id == sync_id) & (frame_len == 4'h0);
    wire unp_busy;
    logic [CW-1:0] pick;
    wire start = ~unp_busy & (|upd_r);

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        assign need_bits[c] = map_bits(map_r[c], cnt_r[c]);
        // Enabled, same identifier, mapping on, enough bytes
        assign match[c] = rx_ok & ~id_r[c][`RPU_ID_DIS_BIT] & (id_r[c][10:0] == frame_id) &
            (cnt_r[c] != 3'h0) & (have_bits >= need_bits[c]);
        assign sync_type[c] = tt_r[c] <= `RPU_TT_SYNC_MAX;
        assign take[c] = start & (pick == CW'(c));
    end

    // Lowest pending channel goes first
    always_comb begin
        pick = '0;
        for (int c = NUM_CH - 1; c >= 0; c--) begin
            if (upd_r[c]) begin
                pick = CW'(c);
            end
        end
    end

    // ----------------------------------------
    // Dictionary decode
    // ----------------------------------------
    wire [15:0] comm_off = od_index - `RPU_COMM_BASE;
    wire [15:0] map_off = od_index - `RPU_MAP_BASE;
    wire comm_hit = comm_off < 16'(NUM_CH);
    wire map_hit = map_off < 16'(NUM_CH);
    wire [CW-1:0] od_ch = comm_hit ? comm_off[CW-1:0] : map_off[CW-1:0];
    wire [2:0] od_ent = od_sub[2:0] - 3'h1;
    wire [9:0] new_bits = map_bits(map_r[od_ch], od_wdata[2:0]);
    // Reserved identifier bits must stay zero
    wire id_ok = od_wdata[30:11] == 20'h0;
    // Reserved and request-only types are refused
    wire tt_ok = (od_wdata[31:8] == 24'h0) &&
        !((od_wdata[7:0] >= `RPU_TT_RSV_LO) && (od_wdata[7:0] <= `RPU_TT_RSV_HI));
    // Four objects, eight bytes at most
    wire cnt_ok = (od_wdata <= `RPU_MAX_OBJ) && (new_bits <= `RPU_MAX_BITS);
    // Whole-byte sizes from one to eight bytes
    wire size_ok = (od_wdata[2:0] == 3'h0) && (od_wdata[7:0] != 8'h0) && (od_wdata[7:0] <= 8'h40);
    // Entries change only while the mapping is off
    wire ent_ok = (cnt_r[od_ch] == 3'h0) && ((od_wdata == 32'h0) || (map_allowed(od_wdata[31:16]) && size_ok));

    logic [31:0] rd_val;
    logic hit_ok;
    logic wr_id;
    logic wr_tt;
    logic wr_cnt;
    logic wr_ent;

    // Address decode; anything not matched aborts
    always_comb begin
        rd_val = 32'h0;
        hit_ok = 1'b0;
        wr_id = 1'b0;
        wr_tt = 1'b0;
        wr_cnt = 1'b0;
        wr_ent = 1'b0;
        if (comm_hit && od_sub == 8'h00) begin
            rd_val = `RPU_COMM_LAST;
            hit_ok = !od_write;
        end else if (comm_hit && od_sub == 8'h01) begin
            rd_val = id_r[od_ch];
            hit_ok = !od_write || id_ok;
            wr_id = od_write && id_ok;
        end else if (comm_hit && od_sub == 8'h02) begin
            rd_val = {24'h0, tt_r[od_ch]};
            hit_ok = !od_write || tt_ok;
            wr_tt = od_write && tt_ok;
        end else if (map_hit && od_sub == 8'h00) begin
            rd_val = {29'h0, cnt_r[od_ch]};
            hit_ok = !od_write || cnt_ok;
            wr_cnt = od_write && cnt_ok;
        end else if (map_hit && od_sub >= 8'h01 && od_sub <= 8'h04) begin
            rd_val = map_r[od_ch][{od_ent[1:0], 5'h00} +: 32];
            hit_ok = !od_write || ent_ok;
            wr_ent = od_write && ent_ok;
        end
    end

    // ----------------------------------------
    // Strap synchroniser and default load
    // ----------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            node_m_r <= 7'h00;
            node_s_r <= 7'h00;
            boot_r <= 2'h0;
            loaded_r <= 1'b0;
        end else begin
            node_m_r <= node_id;
            node_s_r <= node_m_r;
            if (boot_r != 2'h3) begin
                boot_r <= boot_r + 2'h1;
            end
            loaded_r <= loaded_r | (boot_r == 2'h3);
        end
    end

    // ----------------------------------------
    // Configuration, capture and hand-off
    // ----------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int c = 0; c < NUM_CH; c++) begin
                id_r[c] <= 32'h0;
                tt_r[c] <= `RPU_TT_RST;
                cnt_r[c] <= (c == 0) ? `RPU_CNT_RST : 3'h0;
                map_r[c] <= (c == 0) ? {64'h0, `RPU_MAP2_RST, `RPU_MAP1_RST} : 128'h0;
                rxbuf_r[c] <= 64'h0;
                updbuf_r[c] <= 64'h0;
            end
            held_r <= '0;
            upd_r <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                // Identifier defaults follow the node address once settled
                if (!loaded_r && boot_r == 2'h3) begin
                    id_r[c] <= {21'h0, `RPU_ID_BASE + 11'(c) * `RPU_ID_STEP + {4'h0, node_s_r}};
                end
                // Synchronous types park the payload
                if (match[c] && sync_type[c]) begin
                    rxbuf_r[c] <= frame_data;
                end
                // Immediate types hand over at once, SYNC releases parked data
                if (match[c] && !sync_type[c]) begin
                    updbuf_r[c] <= frame_data;
                end else if (is_sync && held_r[c]) begin
                    updbuf_r[c] <= rxbuf_r[c];
                end
                // Leaving operational drops whatever is pending
                if (!nmt_operational) begin
                    held_r[c] <= 1'b0;
                    upd_r[c] <= 1'b0;
                end else begin
                    held_r[c] <= (match[c] && sync_type[c]) || (held_r[c] && !is_sync);
                    // A new hand-over wins over the unpacker taking the old one
                    upd_r[c] <= (match[c] && !sync_type[c]) || (is_sync && held_r[c]) || (upd_r[c] && !take[c]);
                end
            end
            if (od_req && wr_id) begin
                id_r[od_ch] <= od_wdata;
            end
            if (od_req && wr_tt) begin
                tt_r[od_ch] <= od_wdata[7:0];
            end
            if (od_req && wr_cnt) begin
                cnt_r[od_ch] <= od_wdata[2:0];
            end
            if (od_req && wr_ent) begin
                map_r[od_ch][{od_ent[1:0], 5'h00} +: 32] <= od_wdata;
            end
        end
    end

    // Answer one cycle after each request
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            od_ack_r <= 1'b0;
            od_abort_r <= 1'b0;
            od_rdata_r <= 32'h0;
        end else begin
            od_ack_r <= od_req;
            od_abort_r <= od_req && !hit_ok;
            od_rdata_r <= (od_req && !od_write && hit_ok) ? rd_val : 32'h0;
        end
    end

    assign od_ack = od_ack_r;
    assign od_abort = od_abort_r;
    assign od_rdata = od_rdata_r;

    // ----------------------------------------
    // Unpacker
    // ----------------------------------------
    rpu_unpack #(
        .CW(CW)
    ) u_unpack (
        .clock(clock),
        .reset_n(reset_n),
        .start(start),
        .start_chan(pick),
        .start_data(updbuf_r[pick]),
        .start_map(map_r[pick]),
        .start_cnt(cnt_r[pick]),
        .busy(unp_busy),
        .obj_valid(obj_valid),
        .obj_chan(obj_chan),
        .obj_index(obj_index),
        .obj_sub(obj_sub),
        .obj_value(obj_value)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    nmt_gate_a: assert property (!nmt_operational |=> upd_r == '0 && held_r == '0)
        else $error("Pending data kept outside operational");
    id_match_a: assert property (rx_ok && !is_sync && frame_id != id_r[0][10:0] |=> $stable(rxbuf_r[0]))
        else $error("Foreign identifier captured");
    disabled_a: assert property (rx_ok && id_r[0][31] && !is_sync |=> $stable(rxbuf_r[0]) && $stable(updbuf_r[0]))
        else $error("Disabled channel took a frame");
    sync_hold_a: assert property (match[0] && sync_type[0] |=> held_r[0] && rxbuf_r[0] == $past(frame_data) && $stable(updbuf_r[0]))
        else $error("Synchronous data not held for SYNC");
    sync_release_a: assert property (is_sync && held_r[0] |=> upd_r[0] && updbuf_r[0] == $past(rxbuf_r[0]))
        else $error("SYNC did not release held data");
    immediate_a: assert property (match[0] && !sync_type[0] |=> upd_r[0] && updbuf_r[0] == $past(frame_data))
        else $error("Asynchronous data not handed over at once");
    short_frame_a: assert property (rx_ok && !is_sync && have_bits < need_bits[0] |=> $stable(rxbuf_r[0]) && $stable(updbuf_r[0]))
        else $error("Short frame changed channel data");
    tt_refuse_a: assert property (od_req && od_write && od_index == `RPU_COMM_BASE && od_sub == 8'h02 && od_wdata == 32'h0000_00FC |=> od_abort_r && $stable(tt_r[0]))
        else $error("Forbidden transmission type accepted");
    remap_a: assert property (od_req && od_write && map_hit && od_sub == 8'h01 && cnt_r[od_ch] != 3'h0 |=> od_abort_r)
        else $error("Entry rewritten while mapping active");
    strap_a: assert property ($rose(loaded_r) |-> id_r[0][10:0] == `RPU_ID_BASE + {4'h0, $past(node_s_r)})
        else $error("Default identifier not node based");
endmodule : rpu_receive_pdo

// File: hdl/rpu_defines.svh
// Constants of the receive process-data unit: dictionary indices,
// field positions and reset values. Definitions only.
`ifndef RPU_DEFINES_SVH
`define RPU_DEFINES_SVH
`define RPU_COMM_BASE 16'h1400
`define RPU_MAP_BASE 16'h1600
`define RPU_COMM_LAST 32'h0000_0002
`define RPU_ID_DIS_BIT 31
`define RPU_ID_BASE 11'h200
`define RPU_ID_STEP 11'h100
`define RPU_TT_RST 8'hFE
`define RPU_TT_SYNC_MAX 8'hF0
`define RPU_TT_RSV_LO 8'hF1
`define RPU_TT_RSV_HI 8'hFD
`define RPU_CNT_RST 3'h2
`define RPU_MAP1_RST 32'h22AC_0010
`define RPU_MAP2_RST 32'h22AD_0010
`define RPU_MAX_OBJ 32'h0000_0004
`define RPU_MAX_BITS 10'h040
`define RPU_WR_CTRL 16'h22AC
`define RPU_WR_SPEED 16'h22AD
`define RPU_WR_ACCEL 16'h2064
`define RPU_WR_DECEL 16'h2065
`endif

// File: hdl/rpu_pkg.sv
// Types shared by the receive process-data unit files.
// Assumes nothing beyond a SystemVerilog compiler.
package rpu_pkg;
    // Four packed 32-bit mapping entries, entry 1 in the low word
    typedef logic [127:0] rpu_map_type;
    // Unpacker sequencing
    typedef enum logic [1:0] {
        RPU_IDLE = 2'b01,
        RPU_EMIT = 2'b10
    } rpu_unp_state_type;
endpackage : rpu_pkg

// File: hdl/rpu_unpack.sv
// Splits one payload into mapped object writes, one object per cycle.
// Assumes start only arrives while busy is low.
`timescale 1ns/1ps
module rpu_unpack
    import rpu_pkg::*;
#(
    parameter int CW = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Start request
    input wire logic start,
    input wire logic [CW-1:0] start_chan,
    input wire logic [63:0] start_data,
    input wire rpu_map_type start_map,
    input wire logic [2:0] start_cnt,
    output logic busy,
    // Object write stream
    output logic obj_valid,
    output logic [CW-1:0] obj_chan,
    output logic [15:0] obj_index,
    output logic [7:0] obj_sub,
    output logic [63:0] obj_value
);
    // Keeps only the low bits of a value of the given size
    function automatic logic [63:0] size_mask(input logic [7:0] bits);
        if (bits >= 8'h40) begin
            size_mask = 64'hFFFF_FFFF_FFFF_FFFF;
        end else begin
            size_mask = (64'h1 << bits) - 64'h1;
        end
    endfunction : size_mask

    // ----------------------------------------
    // Working copy
    // ----------------------------------------
    rpu_unp_state_type state_r; // Sequencer
    logic [63:0] data_r; // Payload copy, safe from new frames
    rpu_map_type map_r; // Mapping copy, safe from reconfiguration
    logic [2:0] cnt_r; // Active entries
    logic [2:0] pos_r; // Entry being emitted
    logic [3:0] off_r; // Byte offset of that entry
    logic [CW-1:0] chan_r;
    logic obj_valid_r;
    logic [15:0] obj_index_r;
    logic [7:0] obj_sub_r;
    logic [63:0] obj_value_r;

    wire [31:0] cur = map_r[{pos_r[1:0], 5'h00} +: 32];
    wire [63:0] shifted = data_r >> {off_r[2:0], 3'h0}; // Byte 0 is least significant
    wire last = (pos_r + 3'h1) == cnt_r;
    wire [63:0] first_val = start_data & size_mask(start_map[7:0]);

    assign busy = state_r == RPU_EMIT;
    assign obj_valid = obj_valid_r;
    assign obj_chan = chan_r;
    assign obj_index = obj_index_r;
    assign obj_sub = obj_sub_r;
    assign obj_value = obj_value_r;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= RPU_IDLE;
            data_r <= 64'h0;
            map_r <= 128'h0;
            cnt_r <= 3'h0;
            pos_r <= 3'h0;
            off_r <= 4'h0;
            chan_r <= '0;
            obj_valid_r <= 1'b0;
            obj_index_r <= 16'h0;
            obj_sub_r <= 8'h0;
            obj_value_r <= 64'h0;
        end else begin
            obj_valid_r <= 1'b0;
            case (state_r)
                RPU_IDLE: begin
                    // An empty mapping emits nothing
                    if (start && start_cnt != 3'h0) begin
                        data_r <= start_data;
                        map_r <= start_map;
                        cnt_r <= start_cnt;
                        chan_r <= start_chan;
                        pos_r <= 3'h0;
                        off_r <= 4'h0; // Entries fill from byte zero
                        state_r <= RPU_EMIT;
                    end
                end
                RPU_EMIT: begin
                    obj_valid_r <= 1'b1;
                    obj_index_r <= cur[31:16]; // Index, sub-index, size
                    obj_sub_r <= cur[15:8];
                    obj_value_r <= shifted & size_mask(cur[7:0]);
                    pos_r <= pos_r + 3'h1;
                    off_r <= off_r + cur[6:3]; // Next object follows in entry order
                    if (last) begin
                        state_r <= RPU_IDLE;
                    end
                end
                default: begin
                    state_r <= RPU_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    first_object_a: assert property (@(posedge clock) disable iff (!reset_n)
        start && !busy && start_cnt != 3'h0 |-> ##2 obj_valid && obj_value == $past(first_val, 2))
        else $error("First object not taken from payload byte zero");
    object_count_a: assert property (@(posedge clock) disable iff (!reset_n)
        start && !busy && start_cnt == 3'h2 |=> busy [*2] ##1 !busy)
        else $error("Object count differs from mapping count");
endmodule : rpu_unpack

// File: verif/rpu_peer.sv
// Peer node model: puts CAN frames from the network on the frame port.
// Assumes the bench calls send at a falling edge of clock.
`timescale 1ns/1ps
module rpu_peer (
    // Clock
    input wire logic clock,
    // Frame port
    output logic frame_valid,
    output logic [10:0] frame_id,
    output logic frame_rtr,
    output logic [3:0] frame_len,
    output logic [63:0] frame_data
);
    // ------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------
    // Idle: no strobe, data lines hold a pattern of our own
    initial begin
        frame_valid = 1'b0;
        frame_id = 11'h7FF;
        frame_rtr = 1'b0;
        frame_len = 4'h0;
        frame_data = 64'hA5A5_A5A5_A5A5_A5A5;
    end
    // One-cycle strobe; id and data lines invert after so stale data never matches
    task send(input logic [10:0] id, input logic [3:0] len, input logic [63:0] d);
        frame_valid = 1'b1;
        frame_id = id;
        frame_len = len;
        frame_data = d; // Payload bytes only, no index
        @(negedge clock);
        frame_valid = 1'b0;
        frame_id = ~id;
        frame_data = ~d;
    endtask : send
endmodule : rpu_peer

// File: verif/tb_rpu_receive_pdo.sv
// Bench of the receive process-data unit: dictionary and frame tests.
// Assumes the peer model drives the frame port of the unit.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; $display("unexpected %0t %h", $time, a); end end
module tb_rpu_receive_pdo;
    import rpu_pkg::*;
    // Stimulus; node and SYNC id stay fixed for the run
    logic clock = 1'b0, reset_n = 1'b0, nmt_operational = 1'b0, od_req = 1'b0, od_write = 1'b0;
    logic [6:0] node_id = 7'h05;
    logic [10:0] sync_id = 11'h080;
    logic [15:0] od_index = 16'h0;
    logic [7:0] od_sub = 8'h0;
    logic [31:0] od_wdata = 32'h0;
    logic frame_valid, frame_rtr, od_ack, od_abort, obj_valid, ab;
    logic [10:0] frame_id;
    logic [3:0] frame_len;
    logic [63:0] frame_data, obj_value;
    logic [31:0] od_rdata, rd;
    logic [0:0] obj_chan;
    logic [15:0] obj_index;
    logic [7:0] obj_sub;
    logic [88:0] q[$];
    int error_cnt = 0, n_compared = 0;
    // Writes refused by the unit: id bits 11/30, types 252/241, entry at count 2, count 5
    localparam logic [55:0] BAD [6] = '{56'h1400_01_0000_0A05, 56'h1400_01_4000_0205, 56'h1400_02_0000_00FC,
        56'h1400_02_0000_00F1, 56'h1600_01_2064_0008, 56'h1600_00_0000_0005};
    // ------------------------------------------------------------
    // Units and clock
    // ------------------------------------------------------------
    rpu_receive_pdo #(.NUM_CH(2)) dut (.clock, .reset_n, .node_id, .nmt_operational, .sync_id, .frame_valid,
        .frame_id, .frame_rtr, .frame_len, .frame_data, .od_req, .od_write, .od_index, .od_sub, .od_wdata,
        .od_ack, .od_abort, .od_rdata, .obj_valid, .obj_chan, .obj_index, .obj_sub, .obj_value);
    rpu_peer peer (.clock, .frame_valid, .frame_id, .frame_rtr, .frame_len, .frame_data);
    always #20 clock = ~clock;
    // Object writes are queued so tests can check order and values; sampled mid-cycle, away from the launch edge
    always @(negedge clock) begin
        if (obj_valid === 1'b1) q.push_back({obj_chan, obj_sub, obj_index, obj_value});
    end
    // One dictionary request; answer is sampled in the cycle after it
    task od(input logic w, input logic [15:0] i, input logic [7:0] s, input logic [31:0] d);
        @(negedge clock);
        od_req = 1'b1;
        od_write = w;
        od_index = i;
        od_sub = s;
        od_wdata = d;
        @(negedge clock);
        od_req = 1'b0;
        ab = od_abort;
        rd = od_rdata;
        `CHK(od_ack, 1'b1)
    endtask : od
    task rd_chk(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e);
        od(1'b0, i, s, 32'h0);
        `CHK(rd, e)
    endtask : rd_chk
    task wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d, input logic e);
        od(1'b1, i, s, d);
        `CHK(ab, e)
    endtask : wr
    // Frame, then time for the unpacker to finish
    task frame(input logic [10:0] id, input logic [3:0] len, input logic [63:0] d);
        peer.send(id, len, d);
        repeat (8) @(negedge clock);
    endtask : frame
    task obj_chk(input logic [15:0] i, input logic [63:0] v, input logic c = 1'b0);
        logic [88:0] e;
        e = (q.size() > 0) ? q.pop_front() : 89'h0;
        `CHK(e, {c, 8'h00, i, v})
    endtask : obj_chk
    task none;
        `CHK(q.size(), 0)
    endtask : none
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    // Watchdog: the tests need about 7 us
    initial begin
        #100us;
        error_cnt++;
        test_done;
    end
    // Test sequence
    initial begin
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        repeat (6) @(negedge clock);
        rd_chk(16'h1400, 8'h01, 32'h205);
        rd_chk(16'h1401, 8'h01, 32'h305);
        rd_chk(16'h1400, 8'h02, 32'hFE);
        rd_chk(16'h1600, 8'h00, 32'h2);
        rd_chk(16'h1600, 8'h01, 32'h22AC_0010);
        rd_chk(16'h1600, 8'h02, 32'h22AD_0010);
        frame(11'h205, 4'h4, 64'hDDCC_BBAA);
        none;
        nmt_operational = 1'b1;
        frame(11'h205, 4'h4, 64'hDDCC_BBAA);
        obj_chk(16'h22AC, 64'hBBAA);
        obj_chk(16'h22AD, 64'hDDCC);
        frame(11'h206, 4'h4, 64'h1);
        frame(11'h205, 4'h3, 64'h1);
        none;
        wr(16'h1400, 8'h01, 32'h8000_0205, 1'b0);
        frame(11'h205, 4'h4, 64'h1);
        none;
        wr(16'h1400, 8'h01, 32'h205, 1'b0);
        for (int k = 0; k < 6; k++) wr(BAD[k][55:40], BAD[k][39:32], BAD[k][31:0], 1'b1);
        rd_chk(16'h1400, 8'h01, 32'h205);
        wr(16'h1600, 8'h00, 32'h0, 1'b0);
        wr(16'h1600, 8'h01, 32'h2002_0010, 1'b1);
        wr(16'h1600, 8'h01, 32'h1018_0120, 1'b1);
        wr(16'h1600, 8'h01, 32'h2064_0008, 1'b0);
        wr(16'h1600, 8'h02, 32'h2065_0020, 1'b0);
        wr(16'h1600, 8'h03, 32'h22AC_0020, 1'b0);
        wr(16'h1600, 8'h00, 32'h3, 1'b1);
        wr(16'h1600, 8'h00, 32'h2, 1'b0);
        frame(11'h205, 4'h5, 64'h55_4433_2211);
        obj_chk(16'h2064, 64'h11);
        obj_chk(16'h2065, 64'h5544_3322);
        wr(16'h1400, 8'h02, 32'hF0, 1'b0);
        frame(11'h205, 4'h8, 64'h8877_6655_9988_77CC);
        none;
        frame(11'h080, 4'h0, 64'h0); // SYNC has no payload
        obj_chk(16'h2064, 64'hCC);
        obj_chk(16'h2065, 64'h5599_8877);
        frame(11'h205, 4'h8, 64'h1122_3344_5566_7788);
        nmt_operational = 1'b0;
        @(negedge clock);
        nmt_operational = 1'b1;
        frame(11'h080, 4'h0, 64'h0);
        none;
        wr(16'h1400, 8'h02, 32'hFF, 1'b0);
        frame(11'h205, 4'h5, 64'h99_8877_66AB);
        obj_chk(16'h2064, 64'hAB);
        obj_chk(16'h2065, 64'h9988_7766);
        wr(16'h1600, 8'h00, 32'h0, 1'b0);
        frame(11'h205, 4'h8, 64'h1);
        none;
        wr(16'h1601, 8'h01, 32'h2065_0010, 1'b0);
        wr(16'h1601, 8'h00, 32'h1, 1'b0);
        frame(11'h305, 4'h2, 64'hBEEF);
        obj_chk(16'h2065, 64'hBEEF, 1'b1);
        test_done;
    end
endmodule : tb_rpu_receive_pdo
